// >>> hdl/acm_defs.svh
// constants for the alarm channel manager
`ifndef ACM_DEFS_SVH
`define ACM_DEFS_SVH

`define ACM_NUM_ALARMS    4
`define ACM_IDX_MISSING   0
`define ACM_IDX_FREQ      1
`define ACM_IDX_EXTERNAL  3
`define ACM_ADDR_W        4
`define ACM_DATA_W        8
`define ACM_A_DISABLE     4'h0
`define ACM_A_LATCH       4'h1
`define ACM_A_STOP        4'h2
`define ACM_A_RELAY       4'h3
`define ACM_A_ACK         4'h4
`define ACM_A_DETECT      4'h5
`define ACM_A_SIGNAL      4'h6
`define ACM_A_IRQ_STAT    4'h7
`define ACM_A_IRQ_MASK    4'h8
`define ACM_RST_DISABLE   4'h0
`define ACM_RST_LATCH     4'h0
`define ACM_RST_STOP      4'hf
`define ACM_RST_RELAY     4'h0
`define ACM_RST_MASK      4'h0
`define ACM_FIXED_STOP    4'h3

`endif

// >>> hdl/acm_pkg.sv
// types for the alarm channel manager
package acm_pkg;
  typedef logic [3:0] acm_vec_t;
  typedef logic [7:0] acm_byte_t;
  typedef struct packed {
    acm_vec_t  disable_q;
    acm_vec_t  latch_q;
    acm_vec_t  stop_q;
    acm_vec_t  relay_sel_q;
    acm_vec_t  detect_q;
    acm_vec_t  signal_q;
    acm_vec_t  irq_stat_q;
    acm_vec_t  irq_mask_q;
    acm_vec_t  stop_out_q;
    logic      relay_on_q;
    logic      irq_q;
    acm_byte_t rdata_q;
  } acm_state_s;
endpackage

// >>> hdl/acm_alarm_channel_manager.sv
// per-alarm detect, signal, latch, acknowledge, stop and relay logic
`timescale 1ns/1ps
`include "acm_defs.svh"

// Contract
// - disable bit: 0 enabled, 1 disabled
// - disabled alarm: no detect, no action
// - detect flag mirrors present condition
// - signal flag set when alarm occurs
// - latch select keeps signal until acknowledge
// - writing 1 to acknowledge clears signal
// - acknowledge ignored while detect active
// - acknowledge self-clears, never stored
// - stop select routes signal to stop firing
// - missing-supply and frequency stops fixed on
// - relay select lets alarm de-energize relay
// - external channel condition from block input
module acm_alarm_channel_manager (
  input  wire logic                     clock,
  input  wire logic                     arst_n,
  input  wire logic [2:0]               alarm_cond_in,
  input  wire logic                     external_alarm_input,
  input  wire logic [`ACM_ADDR_W-1:0]   reg_addr,
  input  wire logic [`ACM_DATA_W-1:0]   reg_wdata,
  input  wire logic                     reg_write,
  input  wire logic                     reg_read,
  output logic      [`ACM_DATA_W-1:0]   reg_rdata,
  output logic      [3:0]               stop_firing,
  output logic                          alarm_relay_energize,
  output logic                          irq
);

  acm_pkg::acm_state_s st_q;
  acm_pkg::acm_state_s st_d;

  acm_pkg::acm_vec_t raw_cond;
  acm_pkg::acm_vec_t alarm_detected_flag;
  acm_pkg::acm_vec_t alarm_signal_flag;
  acm_pkg::acm_vec_t alarm_acknowledge;
  acm_pkg::acm_vec_t det_next;
  acm_pkg::acm_vec_t sig_next;
  acm_pkg::acm_vec_t new_events;

  // every property below samples on this edge and sleeps in reset
  default clocking acm_cb @(posedge clock);
  endclocking
  default disable iff (!arst_n);

  // address match used only by the acknowledge strobe decode
  function automatic logic hit(input logic [`ACM_ADDR_W-1:0] a,
                               input logic [`ACM_ADDR_W-1:0] r);
    hit = (a == r);
  endfunction

  // external channel takes its level straight from the pin
  assign raw_cond = {external_alarm_input, alarm_cond_in};

  // ack is a strobe only, never a stored bit
  assign alarm_acknowledge = (reg_write && hit(reg_addr, `ACM_A_ACK))
                           ? reg_wdata[3:0] : 4'h0;

  assign alarm_detected_flag = st_q.detect_q;
  assign alarm_signal_flag   = st_q.signal_q;

  // per-alarm detect and signal update
  genvar gi;
  generate
    for (gi = 0; gi < `ACM_NUM_ALARMS; gi++) begin : g_ch
      // a disabled alarm is neither seen nor acted on
      assign det_next[gi] = raw_cond[gi] & ~st_q.disable_q[gi];
      always_comb begin
        if (st_q.disable_q[gi]) begin
          sig_next[gi] = 1'b0;
        end else if (det_next[gi]) begin
          sig_next[gi] = 1'b1;
        end else if (!st_q.latch_q[gi]) begin
          sig_next[gi] = 1'b0;
        end else if (alarm_acknowledge[gi] && !st_q.detect_q[gi]) begin
          sig_next[gi] = 1'b0;
        end else begin
          sig_next[gi] = st_q.signal_q[gi];
        end
      end
    end
  endgenerate

  assign new_events = det_next & ~st_q.detect_q;

  // next state of the whole block
  always_comb begin
    st_d = st_q;
    st_d.detect_q = det_next;
    st_d.signal_q = sig_next;
    // set wins over write-one-to-clear
    st_d.irq_stat_q = st_q.irq_stat_q | new_events;
    if (reg_write) begin
      case (reg_addr)
        `ACM_A_DISABLE:  st_d.disable_q   = reg_wdata[3:0];
        `ACM_A_LATCH:    st_d.latch_q     = reg_wdata[3:0];
        // fixed stop bits cannot be cleared by software
        `ACM_A_STOP:     st_d.stop_q = reg_wdata[3:0] | `ACM_FIXED_STOP;
        `ACM_A_RELAY:    st_d.relay_sel_q = reg_wdata[3:0];
        `ACM_A_IRQ_STAT: st_d.irq_stat_q = (st_q.irq_stat_q & ~reg_wdata[3:0])
                                           | new_events;
        `ACM_A_IRQ_MASK: st_d.irq_mask_q  = reg_wdata[3:0];
        default:         st_d.rdata_q     = st_q.rdata_q;
      endcase
    end
    // stop follows signal, so a latched alarm keeps stopping
    st_d.stop_out_q = sig_next & st_d.stop_q;
    // relay de-energized by any selected signaling alarm
    st_d.relay_on_q = ~|(sig_next & st_d.relay_sel_q);
    st_d.irq_q = |(st_d.irq_stat_q & st_d.irq_mask_q);
    // read data valid only in the cycle after the strobe
    st_d.rdata_q = 8'h00;
    if (reg_read) begin
      case (reg_addr)
        `ACM_A_DISABLE:  st_d.rdata_q = {4'h0, st_q.disable_q};
        `ACM_A_LATCH:    st_d.rdata_q = {4'h0, st_q.latch_q};
        `ACM_A_STOP:     st_d.rdata_q = {4'h0, st_q.stop_q};
        `ACM_A_RELAY:    st_d.rdata_q = {4'h0, st_q.relay_sel_q};
        `ACM_A_ACK:      st_d.rdata_q = 8'h00;
        `ACM_A_DETECT:   st_d.rdata_q = {4'h0, alarm_detected_flag};
        `ACM_A_SIGNAL:   st_d.rdata_q = {4'h0, alarm_signal_flag};
        `ACM_A_IRQ_STAT: st_d.rdata_q = {4'h0, st_q.irq_stat_q};
        `ACM_A_IRQ_MASK: st_d.rdata_q = {4'h0, st_q.irq_mask_q};
        default:         st_d.rdata_q = 8'h00;
      endcase
    end
  end

  // single state register
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= '0;
      st_q.disable_q  <= `ACM_RST_DISABLE;
      st_q.latch_q    <= `ACM_RST_LATCH;
      st_q.stop_q     <= `ACM_RST_STOP;
      st_q.relay_sel_q<= `ACM_RST_RELAY;
      st_q.irq_mask_q <= `ACM_RST_MASK;
      st_q.relay_on_q <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  assign reg_rdata            = st_q.rdata_q;
  assign stop_firing          = st_q.stop_out_q;
  assign alarm_relay_energize = st_q.relay_on_q;
  assign irq                  = st_q.irq_q;

  // assertions, all on the default clock and quiet in reset
  // disabled alarm never shows a detection
  AST_DISABLED_QUIET: assert property (
    st_q.disable_q[0]
      |=> !st_q.detect_q[0])
    else $error("disabled alarm detected");
  // disabled alarm drops its signal next cycle
  AST_DIS_NO_SIGNAL: assert property (
    st_q.disable_q[3]
      |=> !st_q.signal_q[3])
    else $error("disabled alarm still signaling");
  // disabled alarm never holds its channel off
  AST_DIS_NO_STOP: assert property (
    st_q.disable_q[2]
      |=> !stop_firing[2])
    else $error("disabled alarm stops firing");
  // with every alarm disabled the relay is energized
  AST_DIS_NO_RELAY: assert property (
    (st_q.disable_q == 4'hf)
      |=> alarm_relay_energize)
    else $error("disabled alarms dropped relay");
  // detect follows the condition one cycle later
  AST_DETECT_TRACK: assert property (
    (raw_cond[1] && !st_q.disable_q[1])
      |=> st_q.detect_q[1])
    else $error("detect flag missed condition");
  // detect set for the missing supply channel too
  AST_DETECT_SET0: assert property (
    (raw_cond[0] && !st_q.disable_q[0])
      |=> st_q.detect_q[0])
    else $error("detect flag missed supply condition");
  // detect falls once the condition is gone
  AST_DETECT_CLEAR: assert property (
    !raw_cond[2]
      |=> !st_q.detect_q[2])
    else $error("detect flag stuck");
  // a live detection always signals
  AST_SIG_SET: assert property (
    st_q.detect_q[2]
      |-> st_q.signal_q[2])
    else $error("signal not set with detect");
  // same for the missing supply channel
  AST_SIG_SET0: assert property (
    st_q.detect_q[0]
      |-> st_q.signal_q[0])
    else $error("supply signal not set with detect");
  // a signal only rises together with a detection
  AST_SIG_CAUSE: assert property (
    $rose(st_q.signal_q[1])
      |-> st_q.detect_q[1])
    else $error("signal rose without detect");
  // unlatched signal drops with the condition
  AST_NOLATCH: assert property (
    (!st_q.latch_q[3] && !det_next[3] && !$past(st_q.latch_q[3]))
      |=> !st_q.signal_q[3])
    else $error("unlatched signal held");
  // unlatched generic alarm drops with its condition
  AST_NOLATCH_DROP2: assert property (
    (!st_q.latch_q[2] && !det_next[2])
      |=> !st_q.signal_q[2])
    else $error("unlatched generic signal held");
  // latched signal holds until acknowledged
  AST_LATCH_HOLD: assert property (
    (st_q.latch_q[2] && st_q.signal_q[2] && !st_q.disable_q[2]
     && !alarm_acknowledge[2]) |=> st_q.signal_q[2])
    else $error("latched signal lost");
  // ack of a quiet alarm clears its signal
  AST_ACK_CLEARS: assert property (
    (alarm_acknowledge[2] && !det_next[2] && !st_q.detect_q[2])
      |=> !st_q.signal_q[2])
    else $error("ack failed to clear signal");
  // same for the external channel
  AST_ACK_CLEARS3: assert property (
    (alarm_acknowledge[3] && !det_next[3] && !st_q.detect_q[3])
      |=> !st_q.signal_q[3])
    else $error("ack failed to clear external signal");
  // ack against a live condition leaves signal set
  AST_ACK_BLOCKED: assert property (
    (alarm_acknowledge[2] && det_next[2])
      |=> st_q.signal_q[2])
    else $error("ack cleared active alarm");
  // ack while detect still shows the alarm is refused
  AST_ACK_BLOCKED0: assert property (
    (alarm_acknowledge[0] && st_q.detect_q[0] && !st_q.disable_q[0])
      |=> st_q.signal_q[0])
    else $error("ack cleared detected alarm");
  // the ack location always reads back zero
  AST_ACK_READS_ZERO: assert property (
    (reg_read && reg_addr == `ACM_A_ACK)
      |=> (reg_rdata == 8'h00))
    else $error("ack location held a value");
  // no ack strobe without a write
  AST_ACK_IDLE: assert property (
    !reg_write
      |-> (alarm_acknowledge == 4'h0))
    else $error("ack strobe without write");
  // a signaling alarm with stop selected holds firing off
  AST_STOP_FOLLOW: assert property (
    st_q.signal_q[0]
      |-> stop_firing[0])
    else $error("stop not driven");
  // latched generic alarm keeps stopping while selected
  AST_STOP_LATCHED: assert property (
    (st_q.signal_q[2] && st_q.stop_q[2])
      |-> stop_firing[2])
    else $error("latched stop lost");
  // without stop selected the channel keeps firing
  AST_STOP_DESELECT: assert property (
    !st_q.stop_q[3]
      |-> !stop_firing[3])
    else $error("stop without selection");
  // fixed stop bits stay set whatever is written
  AST_FIXED_STOP: assert property (
    1'b1
      |-> ((st_q.stop_q & `ACM_FIXED_STOP) == `ACM_FIXED_STOP))
    else $error("fixed stop changed");
  // a write of the stop register keeps the fixed bits
  AST_FIXED_STOP_WR: assert property (
    (reg_write && reg_addr == `ACM_A_STOP)
      |=> ((st_q.stop_q & `ACM_FIXED_STOP) == `ACM_FIXED_STOP))
    else $error("fixed stop cleared by write");
  // external pin raises the external detection
  AST_EXT_TRACK: assert property (
    (external_alarm_input && !st_q.disable_q[3])
      |=> st_q.detect_q[3])
    else $error("external condition missed");
  // external detection falls with the pin
  AST_EXT_CLEAR: assert property (
    !external_alarm_input
      |=> !st_q.detect_q[3])
    else $error("external detect stuck");
  // a selected signaling alarm drops the relay
  AST_RELAY: assert property (
    (st_q.signal_q[2] && st_q.relay_sel_q[2])
      |-> !alarm_relay_energize)
    else $error("relay energized during alarm");
  // no selected signal leaves the relay energized
  AST_RELAY_ON: assert property (
    ((st_q.signal_q & st_q.relay_sel_q) == 4'h0)
      |-> alarm_relay_energize)
    else $error("relay dropped without alarm");
  // irq level mirrors unmasked sticky status
  AST_IRQ_LEVEL: assert property (
    1'b1
      |-> (irq == |(st_q.irq_stat_q & st_q.irq_mask_q)))
    else $error("irq level wrong");
  // read data idle at zero outside the answer cycle
  AST_RDATA_IDLE: assert property (
    !reg_read
      |=> (reg_rdata == 8'h00))
    else $error("read data outside answer cycle");
  // latched alarm cleared by ack once quiet
  COV_LATCH_ACK: cover property (
    st_q.signal_q[2] && !st_q.detect_q[2] ##1 !st_q.signal_q[2]);
  // ack refused against a live alarm
  COV_ACK_REFUSED: cover property (
    alarm_acknowledge[2] && det_next[2]);
  // relay dropped by a selected alarm
  COV_RELAY_OFF: cover property (
    !alarm_relay_energize);
  // unmasked event raises the interrupt
  COV_IRQ: cover property (
    irq);
  // external alarm holds its channel off
  COV_EXT_STOP: cover property (
    st_q.detect_q[3] && stop_firing[3]);

endmodule

// >>> sim/acm_firing_model.sv
// firing stage and relay coil model facing the manager outputs
`timescale 1ns/1ps
module acm_firing_model (
  input  wire logic       clock,
  input  wire logic       arst_n,
  input  wire logic [3:0] stop_firing,
  input  wire logic       alarm_relay_energize,
  output logic      [3:0] firing,
  output logic            relay_closed
);
  // a channel fires every cycle unless held off; coil follows its drive
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      firing       <= 4'h0;
      relay_closed <= 1'b0;
    end else begin
      firing       <= ~stop_firing;
      relay_closed <= alarm_relay_energize;
    end
  end
endmodule

// >>> sim/tb_acm_alarm_channel_manager.sv
// self-checking bench for the alarm channel manager
`timescale 1ns/1ps
`include "acm_defs.svh"
module tb_acm_alarm_channel_manager;
  logic       clock, arst_n, ext, wr_s, rd_s, relay, irq, rly;
  logic [2:0] cond;
  logic [3:0] addr, stop, fire;
  logic [7:0] wdata, rdata;
  int         errors, compares;
  // 20 MHz clock
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  acm_alarm_channel_manager dut (.clock(clock), .arst_n(arst_n),
    .alarm_cond_in(cond), .external_alarm_input(ext), .reg_addr(addr),
    .reg_wdata(wdata), .reg_write(wr_s), .reg_read(rd_s),
    .reg_rdata(rdata), .stop_firing(stop),
    .alarm_relay_energize(relay), .irq(irq));
  acm_firing_model fm (.clock(clock), .arst_n(arst_n), .stop_firing(stop),
    .alarm_relay_energize(relay), .firing(fire), .relay_closed(rly));
  task chk(input string n, input logic [7:0] s, input logic [7:0] e);
    compares++;
    if (s !== e) begin
      errors++;
      $display("MISMATCH %s exp %h seen %h", n, e, s);
    end
  endtask
  // let the edges land, then look at settled levels
  task tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clock);
    addr <= a; wdata <= v; wr_s <= 1'b1;
    @(posedge clock);
    wr_s <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task rc(input logic [3:0] a, input logic [7:0] e);
    @(posedge clock);
    addr <= a; rd_s <= 1'b1;
    @(posedge clock);
    rd_s <= 1'b0;
    #1 chk($sformatf("reg %h", a), rdata, e);
  endtask
  task tally_and_finish;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // watchdog well beyond the hundred or so cycles the tests need
  initial begin
    #200000;
    errors++;
    tally_and_finish;
  end
  task test_defaults;
    rc(`ACM_A_DISABLE, 8'h00);
    rc(`ACM_A_STOP, 8'h0f);
    rc(4'hf, 8'h00);
    tick(1); chk("relay", 8'(rly), 8'h01);
    $display("reset done");
  endtask
  task test_live;
    @(posedge clock) cond <= 3'h4;
    tick(3); rc(`ACM_A_DETECT, 8'h04);
    rc(`ACM_A_SIGNAL, 8'h04);
    chk("fire", 8'(fire), 8'h0b);
    @(posedge clock) cond <= 3'h0;
    tick(3); rc(`ACM_A_SIGNAL, 8'h00);
    $display("live done");
  endtask
  task test_latch;
    wr(`ACM_A_LATCH, 8'h04); wr(`ACM_A_RELAY, 8'h04);
    @(posedge clock) cond <= 3'h4;
    tick(3); chk("relay", 8'(rly), 8'h00);
    wr(`ACM_A_ACK, 8'h04); rc(`ACM_A_SIGNAL, 8'h04);
    @(posedge clock) cond <= 3'h0;
    tick(3); rc(`ACM_A_SIGNAL, 8'h04);
    chk("relay", 8'(rly), 8'h00);
    chk("fire", 8'(fire), 8'h0b);
    wr(`ACM_A_ACK, 8'h04); rc(`ACM_A_SIGNAL, 8'h00);
    rc(`ACM_A_ACK, 8'h00);
    tick(2); chk("relay", 8'(rly), 8'h01);
    chk("fire", 8'(fire), 8'h0f);
    $display("latch done");
  endtask
  task test_disable;
    wr(`ACM_A_DISABLE, 8'h08); wr(`ACM_A_RELAY, 8'h08);
    @(posedge clock) ext <= 1'b1;
    tick(3); rc(`ACM_A_DETECT, 8'h00);
    chk("fire", 8'(fire), 8'h0f);
    chk("relay", 8'(rly), 8'h01);
    wr(`ACM_A_DISABLE, 8'h00);
    tick(3); rc(`ACM_A_DETECT, 8'h08);
    chk("fire", 8'(fire), 8'h07);
    chk("relay", 8'(rly), 8'h00);
    @(posedge clock) ext <= 1'b0;
    $display("disable done");
  endtask
  task test_fixed_stop;
    wr(`ACM_A_STOP, 8'h00); rc(`ACM_A_STOP, 8'(`ACM_FIXED_STOP));
    @(posedge clock) cond <= 3'h1;
    tick(3); chk("fire", 8'(fire), 8'h0e);
    @(posedge clock) cond <= 3'h0;
    $display("fixed stop done");
  endtask
  task test_irq;
    rc(`ACM_A_IRQ_STAT, 8'h0d);
    chk("irq", 8'(irq), 8'h00);
    wr(`ACM_A_IRQ_MASK, 8'h01);
    tick(2); chk("irq", 8'(irq), 8'h01);
    wr(`ACM_A_IRQ_STAT, 8'h0d);
    tick(2); chk("irq", 8'(irq), 8'h00);
    rc(`ACM_A_IRQ_STAT, 8'h00);
    $display("irq done");
  endtask
  // reset in mid-run with a latched alarm and changed settings
  task test_midrun_reset;
    wr(`ACM_A_IRQ_MASK, 8'h04);
    @(posedge clock) cond <= 3'h4;
    tick(3);
    @(posedge clock);
    arst_n <= 1'b0;
    cond   <= 3'h0;
    tick(1); chk("relay_rst", 8'(relay), 8'h01);
    chk("irq_rst", 8'(irq), 8'h00);
    chk("stop_rst", 8'(stop), 8'h00);
    @(posedge clock);
    arst_n <= 1'b1;
    rc(`ACM_A_LATCH, 8'h00);
    rc(`ACM_A_STOP, 8'h0f);
    rc(`ACM_A_RELAY, 8'h00);
    rc(`ACM_A_SIGNAL, 8'h00);
    rc(`ACM_A_IRQ_STAT, 8'h00);
    rc(`ACM_A_IRQ_MASK, 8'h00);
    $display("midrun reset done");
  endtask
  initial begin
    {ext, wr_s, rd_s, cond, addr, wdata} = '0;
    arst_n = 1'b0;
    repeat (2) @(posedge clock);
    arst_n <= 1'b1;
    test_defaults;
    test_live;
    test_latch;
    test_disable;
    test_fixed_stop;
    test_irq;
    test_midrun_reset;
    tally_and_finish;
  end
endmodule
